/* hdl/vcc_regs.sv */
// How it works
// - Soft reset bit set holds digital functions in their power-on state.
// - Soft reset leaves the serial port and registers 0x20 to 0x28 untouched, but clears the buffered divider and oscillator fields.
// - Hardware never clears soft reset; software writes zero to release.
// - Register 0x20 bit 3 gates the calibration ADC clock.
// - Register 0x23 bit 7 picks the calibration count setting.
// - Halving bit halves reference and feedback calibration clocks.
// - Register 0x25 bit 7 double-buffers the output clock divider.
// - Register 0x25 bit 6 double-buffers both calibration dividers.
// - Register 0x26 sets time per band decision step.
// - Register 0x27 holds timeout bits 7 to 0.
// - Register 0x28 bits 6 to 0 hold timeout bits 14 to 8.
// - Register 0x28 bit 7 double-buffers manual core, band, bias fields.
// - All registers come out of reset as zero.
`timescale 1ns/1ps
module vcc_regs
  import vcc_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  // serial port register access
  input  wire vcc_port_req_t              port_req,
  output logic      [7:0]                 port_rdata,
  output logic                            port_rvalid,
  // buffered field writes and update event
  input  wire vcc_out_div_wr_t            out_div_wr,
  input  wire vcc_cal_div_wr_t            cal_div_wr,
  input  wire vcc_osc_wr_t                osc_wr,
  input  wire logic                       update_event,
  // calibration clock ticks
  input  wire logic                       cal_active,
  input  wire logic                       cal_ref_tick,
  input  wire logic                       cal_fb_tick,
  output logic                            cal_ref_tick_out,
  output logic                            cal_fb_tick_out,
  // controls
  output logic                            digital_soft_reset,
  output logic                            adc_clock_enable,
  output logic                            cal_count_choice,
  output logic                            cal_clock_halving,
  output logic      [7:0]                 band_decision_time,
  output logic      [TIMEOUT_WIDTH-1:0]   dac_settle_timeout,
  output logic                            out_divider_shadow_en,
  output logic                            cal_divider_shadow_en,
  output logic                            manual_osc_shadow_en,
  // applied buffered fields
  output logic      [OUT_DIV_WIDTH-1:0]   output_clock_divider,
  output logic      [CAL_DIV_WIDTH-1:0]   cal_divider_first,
  output logic      [CAL_DIV_WIDTH-1:0]   cal_divider_second,
  output logic      [OSC_CORE_WIDTH-1:0]  manual_osc_core,
  output logic      [OSC_BAND_WIDTH-1:0]  manual_osc_band,
  output logic      [OSC_BIAS_WIDTH-1:0]  manual_osc_bias
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic                      soft_reset;
    logic                      adc_clk_en;
    logic                      count_choice;
    logic                      halving;
    logic [7:0]                decision;
    logic [TIMEOUT_WIDTH-1:0]  timeout;
    logic                      out_div_db;
    logic                      cal_div_db;
    logic                      osc_db;
    logic                      ref_phase;
    logic                      fb_phase;
    logic                      ref_out;
    logic                      fb_out;
  } vcc_regs_state_t;

  vcc_regs_state_t state;
  vcc_regs_state_t next_state;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr);
    return (addr >= ADDR_SOFT_RESET_ADC_CLOCK) &&
           (addr <= ADDR_MANUAL_VCO_BUFFER_ENABLE);
  endfunction

  function automatic logic [3:0] addr_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - ADDR_SOFT_RESET_ADC_CLOCK;
    return diff[3:0];
  endfunction

  // one tick through, or every second tick when halving
  function automatic logic [1:0] halve_tick(input logic tick,
                                            input logic halve,
                                            input logic phase);
    logic pass;
    pass = tick && (!halve || phase);
    return {pass, tick ? !phase : phase};
  endfunction

  logic [1:0] ref_step;
  logic [1:0] fb_step;

  always_comb begin
    next_state        = state;
    next_state.rvalid = 1'b0;
    ref_step = halve_tick(cal_ref_tick, state.halving, state.ref_phase);
    fb_step  = halve_tick(cal_fb_tick, state.halving, state.fb_phase);

    // -------------------------------------------------------------
    // register writes and reads
    // -------------------------------------------------------------
    // writes only come from the port, so the soft reset never blocks
    // them and no hardware path clears the soft reset bit
    if (port_req.wr && addr_hit(port_req.addr)) begin
      next_state.regs[addr_index(port_req.addr)] = port_req.wdata;
    end
    if (port_req.rd) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = addr_hit(port_req.addr) ?
                          state.regs[addr_index(port_req.addr)] :
                          READ_UNMAPPED;
    end

    // -------------------------------------------------------------
    // decoded controls
    // -------------------------------------------------------------
    next_state.soft_reset =
      state.regs[IDX_SOFT_RESET][BIT_DIGITAL_SOFT_RESET];
    next_state.adc_clk_en =
      state.regs[IDX_SOFT_RESET][BIT_ADC_CLOCK_ENABLE];
    next_state.count_choice =
      state.regs[IDX_COUNT_SELECT][BIT_CAL_COUNT_CHOICE];
    next_state.halving =
      state.regs[IDX_HALVING][BIT_CAL_CLOCK_HALVING];
    next_state.out_div_db =
      state.regs[IDX_BUFFER_EN][BIT_OUT_DIVIDER_SHADOW];
    next_state.cal_div_db =
      state.regs[IDX_BUFFER_EN][BIT_CAL_DIVIDER_SHADOW];
    next_state.decision = state.regs[IDX_DECISION];
    next_state.timeout  = {
      state.regs[IDX_TIMEOUT_HIGH][TIMEOUT_HIGH_MSB:0],
      state.regs[IDX_TIMEOUT_LOW]};
    next_state.osc_db =
      state.regs[IDX_TIMEOUT_HIGH][BIT_MANUAL_OSC_SHADOW];

    // -------------------------------------------------------------
    // calibration clock halving
    // -------------------------------------------------------------
    if (state.soft_reset || !cal_active) begin
      next_state.ref_phase = 1'b0;
      next_state.fb_phase  = 1'b0;
      next_state.ref_out   = 1'b0;
      next_state.fb_out    = 1'b0;
    end else begin
      next_state.ref_out   = ref_step[1];
      next_state.ref_phase = ref_step[0];
      next_state.fb_out    = fb_step[1];
      next_state.fb_phase  = fb_step[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // double-buffered fields
  // ---------------------------------------------------------------
  logic [CAL_GROUP_WIDTH-1:0] cal_active_bits;
  logic [OSC_GROUP_WIDTH-1:0] osc_active_bits;

  vcc_shadow #(.WIDTH(OUT_DIV_WIDTH)) u_out_div (
    .core_clk  (core_clk),
    .reset     (reset),
    .clear     (state.soft_reset),
    .shadow_en (state.out_div_db),
    .update    (update_event),
    .strobe    (out_div_wr.strobe),
    .value     (out_div_wr.output_clock_divider),
    .active    (output_clock_divider)
  );

  vcc_shadow #(.WIDTH(CAL_GROUP_WIDTH)) u_cal_div (
    .core_clk  (core_clk),
    .reset     (reset),
    .clear     (state.soft_reset),
    .shadow_en (state.cal_div_db),
    .update    (update_event),
    .strobe    (cal_div_wr.strobe),
    .value     ({cal_div_wr.cal_divider_second,
                 cal_div_wr.cal_divider_first}),
    .active    (cal_active_bits)
  );

  vcc_shadow #(.WIDTH(OSC_GROUP_WIDTH)) u_osc (
    .core_clk  (core_clk),
    .reset     (reset),
    .clear     (state.soft_reset),
    .shadow_en (state.osc_db),
    .update    (update_event),
    .strobe    (osc_wr.strobe),
    .value     ({osc_wr.manual_osc_core,
                 osc_wr.manual_osc_band,
                 osc_wr.manual_osc_bias}),
    .active    (osc_active_bits)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign port_rdata            = state.rdata;
  assign port_rvalid           = state.rvalid;
  assign digital_soft_reset    = state.soft_reset;
  assign adc_clock_enable      = state.adc_clk_en;
  assign cal_count_choice      = state.count_choice;
  assign cal_clock_halving     = state.halving;
  assign band_decision_time    = state.decision;
  assign dac_settle_timeout    = state.timeout;
  assign out_divider_shadow_en = state.out_div_db;
  assign cal_divider_shadow_en = state.cal_div_db;
  assign manual_osc_shadow_en  = state.osc_db;
  assign cal_ref_tick_out      = state.ref_out;
  assign cal_fb_tick_out       = state.fb_out;
  assign cal_divider_first     = cal_active_bits[CAL_DIV_WIDTH-1:0];
  assign cal_divider_second    =
    cal_active_bits[CAL_GROUP_WIDTH-1:CAL_DIV_WIDTH];
  assign manual_osc_bias       = osc_active_bits[OSC_BIAS_WIDTH-1:0];
  assign manual_osc_band       =
    osc_active_bits[OSC_BIAS_WIDTH+OSC_BAND_WIDTH-1:OSC_BIAS_WIDTH];
  assign manual_osc_core       =
    osc_active_bits[OSC_GROUP_WIDTH-1:OSC_BIAS_WIDTH+OSC_BAND_WIDTH];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic wr_soft_reg;
  assign wr_soft_reg = port_req.wr &&
                       (port_req.addr == ADDR_SOFT_RESET_ADC_CLOCK);

  property p_soft_reset_hold;
    @(posedge core_clk) disable iff (reset)
    (port_req.wr && port_req.addr == ADDR_SOFT_RESET_ADC_CLOCK &&
     port_req.wdata[BIT_DIGITAL_SOFT_RESET])
    |=> ##1 digital_soft_reset ##1 !cal_ref_tick_out;
  endproperty
  a_soft_reset_hold: assert property (p_soft_reset_hold)
    else $error("soft reset not applied two cycles after write");

  property p_regs_kept;
    @(posedge core_clk) disable iff (reset)
    (digital_soft_reset && !port_req.wr) |=> $stable(state.regs);
  endproperty
  a_regs_kept: assert property (p_regs_kept)
    else $error("registers changed under soft reset without a write");

  property p_soft_sticky;
    @(posedge core_clk) disable iff (reset)
    (state.regs[IDX_SOFT_RESET][BIT_DIGITAL_SOFT_RESET] && !wr_soft_reg)
    |=> state.regs[IDX_SOFT_RESET][BIT_DIGITAL_SOFT_RESET];
  endproperty
  a_soft_sticky: assert property (p_soft_sticky)
    else $error("soft reset bit cleared without a write");

  property p_adc_clock;
    @(posedge core_clk) disable iff (reset)
    (port_req.wr && port_req.addr == ADDR_SOFT_RESET_ADC_CLOCK)
    |=> ##1 adc_clock_enable == $past(port_req.wdata[BIT_ADC_CLOCK_ENABLE], 2);
  endproperty
  a_adc_clock: assert property (p_adc_clock)
    else $error("adc clock enable does not follow written bit");

  property p_count_choice;
    @(posedge core_clk) disable iff (reset)
    (port_req.wr && port_req.addr == ADDR_CAL_COUNT_SELECT)
    |=> ##1 cal_count_choice == $past(port_req.wdata[BIT_CAL_COUNT_CHOICE], 2);
  endproperty
  a_count_choice: assert property (p_count_choice)
    else $error("count choice does not follow written bit");

  property p_halve_off;
    @(posedge core_clk) disable iff (reset)
    (!cal_clock_halving && !digital_soft_reset && cal_active &&
     cal_ref_tick) |=> cal_ref_tick_out;
  endproperty
  a_halve_off: assert property (p_halve_off)
    else $error("reference tick lost with halving off");

  property p_halve_on;
    @(posedge core_clk) disable iff (reset)
    (cal_clock_halving && $past(cal_clock_halving) && cal_fb_tick &&
     cal_fb_tick_out) |=> !cal_fb_tick_out;
  endproperty
  a_halve_on: assert property (p_halve_on)
    else $error("feedback tick passed twice running with halving on");

  property p_direct_write;
    @(posedge core_clk) disable iff (reset)
    (!out_divider_shadow_en && out_div_wr.strobe && !digital_soft_reset)
    |=> output_clock_divider == $past(out_div_wr.output_clock_divider);
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("unbuffered divider write not applied at once");

  property p_buffered_hold;
    @(posedge core_clk) disable iff (reset)
    (cal_divider_shadow_en && cal_div_wr.strobe && !update_event &&
     !digital_soft_reset) |=> $stable(cal_divider_first) &&
                              $stable(cal_divider_second);
  endproperty
  a_buffered_hold: assert property (p_buffered_hold)
    else $error("buffered calibration divider changed before update");

  property p_osc_update;
    @(posedge core_clk) disable iff (reset)
    (manual_osc_shadow_en && osc_wr.strobe && !digital_soft_reset) ##1
    (!osc_wr.strobe && !digital_soft_reset)[*2] ##1
    (update_event && !digital_soft_reset) |=>
    manual_osc_band == $past(osc_wr.manual_osc_band, 4);
  endproperty
  a_osc_update: assert property (p_osc_update)
    else $error("buffered oscillator band not applied on update");

  property p_timeout;
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> ##1 dac_settle_timeout ==
      {$past(state.regs[IDX_TIMEOUT_HIGH][TIMEOUT_HIGH_MSB:0]),
       $past(state.regs[IDX_TIMEOUT_LOW])} &&
      band_decision_time == $past(state.regs[IDX_DECISION]);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout or decision time mismatches registers");

  property p_reset_zero;
    @(posedge core_clk)
    $past(reset) |-> state.regs == '0 && !digital_soft_reset;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

  property p_soft_set;
    @(posedge core_clk) disable iff (reset)
    $rose(digital_soft_reset);
  endproperty
  c_soft_set: cover property (p_soft_set);

  property p_halved;
    @(posedge core_clk) disable iff (reset)
    cal_clock_halving && cal_ref_tick_out;
  endproperty
  c_halved: cover property (p_halved);

  property p_shadow_update;
    @(posedge core_clk) disable iff (reset)
    manual_osc_shadow_en && update_event;
  endproperty
  c_shadow_update: cover property (p_shadow_update);

endmodule // vcc_regs

/* hdl/vcc_pkg.sv */
package vcc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SOFT_RESET_ADC_CLOCK      = 8'h20;
  localparam logic [7:0] ADDR_RESERVED_CFG_A            = 8'h21;
  localparam logic [7:0] ADDR_RESERVED_CFG_B            = 8'h22;
  localparam logic [7:0] ADDR_CAL_COUNT_SELECT          = 8'h23;
  localparam logic [7:0] ADDR_CAL_CLOCK_HALVING         = 8'h24;
  localparam logic [7:0] ADDR_DIVIDER_BUFFER_ENABLES    = 8'h25;
  localparam logic [7:0] ADDR_BAND_DECISION_TIME        = 8'h26;
  localparam logic [7:0] ADDR_SETTLE_TIMEOUT_LOW        = 8'h27;
  localparam logic [7:0] ADDR_MANUAL_VCO_BUFFER_ENABLE  = 8'h28;
  localparam int         REG_COUNT                      = 9;
  localparam logic [7:0] REG_RESET_VALUE                = 8'h00;
  localparam logic [7:0] READ_UNMAPPED                  = 8'h00;

  // ---------------------------------------------------------------
  // register indices, counted from the first address
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_SOFT_RESET    = 4'h0;
  localparam logic [3:0] IDX_COUNT_SELECT  = 4'h3;
  localparam logic [3:0] IDX_HALVING       = 4'h4;
  localparam logic [3:0] IDX_BUFFER_EN     = 4'h5;
  localparam logic [3:0] IDX_DECISION      = 4'h6;
  localparam logic [3:0] IDX_TIMEOUT_LOW   = 4'h7;
  localparam logic [3:0] IDX_TIMEOUT_HIGH  = 4'h8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_DIGITAL_SOFT_RESET   = 4;
  localparam int BIT_ADC_CLOCK_ENABLE     = 3;
  localparam int BIT_CAL_COUNT_CHOICE     = 7;
  localparam int BIT_CAL_CLOCK_HALVING    = 2;
  localparam int BIT_OUT_DIVIDER_SHADOW   = 7;
  localparam int BIT_CAL_DIVIDER_SHADOW   = 6;
  localparam int BIT_MANUAL_OSC_SHADOW    = 7;
  localparam int TIMEOUT_HIGH_MSB         = 6;
  localparam int TIMEOUT_WIDTH            = 15;

  // ---------------------------------------------------------------
  // widths of the buffered fields kept elsewhere in the map
  // ---------------------------------------------------------------
  localparam int OUT_DIV_WIDTH    = 3;
  localparam int CAL_DIV_WIDTH    = 2;
  localparam int OSC_CORE_WIDTH   = 2;
  localparam int OSC_BAND_WIDTH   = 8;
  localparam int OSC_BIAS_WIDTH   = 3;
  localparam int CAL_GROUP_WIDTH  = 2 * CAL_DIV_WIDTH;
  localparam int OSC_GROUP_WIDTH  =
    OSC_CORE_WIDTH + OSC_BAND_WIDTH + OSC_BIAS_WIDTH;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vcc_port_req_t;

  typedef struct packed {
    logic       strobe;
    logic [OUT_DIV_WIDTH-1:0] output_clock_divider;
  } vcc_out_div_wr_t;

  typedef struct packed {
    logic       strobe;
    logic [CAL_DIV_WIDTH-1:0] cal_divider_second;
    logic [CAL_DIV_WIDTH-1:0] cal_divider_first;
  } vcc_cal_div_wr_t;

  typedef struct packed {
    logic       strobe;
    logic [OSC_CORE_WIDTH-1:0] manual_osc_core;
    logic [OSC_BAND_WIDTH-1:0] manual_osc_band;
    logic [OSC_BIAS_WIDTH-1:0] manual_osc_bias;
  } vcc_osc_wr_t;

endpackage

/* hdl/vcc_shadow.sv */
`timescale 1ns/1ps
module vcc_shadow
  import vcc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clear,
  // control
  input  wire logic             shadow_en,
  input  wire logic             update,
  // field write
  input  wire logic             strobe,
  input  wire logic [WIDTH-1:0] value,
  // applied value
  output logic      [WIDTH-1:0] active
);

  typedef struct packed {
    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] active;
  } vcc_shadow_state_t;

  vcc_shadow_state_t state;
  vcc_shadow_state_t next_state;

  // ---------------------------------------------------------------
  // held stage and applied stage
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state = '0;
    end else begin
      if (update) begin
        next_state.active = state.held;
      end
      if (strobe) begin
        next_state.held = value;
        if (!shadow_en) begin
          next_state.active = value;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active = state.active;

endmodule // vcc_shadow

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import vcc_pkg::*;
  // ----------------------------------------
  // clock, reset, stimulus
  // ----------------------------------------
  logic            core_clk = 1'b0;
  logic            reset = 1'b1;
  vcc_port_req_t   port_req = '0;
  vcc_out_div_wr_t out_div_wr = '0;
  vcc_cal_div_wr_t cal_div_wr = '0;
  vcc_osc_wr_t     osc_wr = '0;
  logic            update_event = 1'b0;
  logic            cal_active = 1'b0;
  logic            tick = 1'b0;
  logic      [7:0] rdata;
  logic            rvalid, ref_out, fb_out, srst, adc_en, cnt_ch, halv;
  logic      [7:0] band;
  logic     [14:0] tmo;
  logic            o_sh, c_sh, m_sh;
  logic      [2:0] odiv, bias;
  logic      [1:0] c1, c2, core;
  logic      [7:0] oband;
  logic      [6:0] ctl;
  int              failures = 0, checked = 0, cycles = 0, nref = 0, nfb = 0;
  logic      [7:0] pat [9] = '{8'h08, 8'ha5, 8'h5a, 8'hff, 8'hfe, 8'hc3,
                             8'h7e, 8'ha5, 8'hda};

  vcc_regs dut (.core_clk(core_clk), .reset(reset), .port_req(port_req),
    .port_rdata(rdata), .port_rvalid(rvalid), .out_div_wr(out_div_wr),
    .cal_div_wr(cal_div_wr), .osc_wr(osc_wr), .update_event(update_event),
    .cal_active(cal_active), .cal_ref_tick(tick), .cal_fb_tick(tick),
    .cal_ref_tick_out(ref_out), .cal_fb_tick_out(fb_out),
    .digital_soft_reset(srst), .adc_clock_enable(adc_en),
    .cal_count_choice(cnt_ch), .cal_clock_halving(halv),
    .band_decision_time(band), .dac_settle_timeout(tmo),
    .out_divider_shadow_en(o_sh), .cal_divider_shadow_en(c_sh),
    .manual_osc_shadow_en(m_sh), .output_clock_divider(odiv),
    .cal_divider_first(c1), .cal_divider_second(c2),
    .manual_osc_core(core), .manual_osc_band(oband),
    .manual_osc_bias(bias));

  assign ctl = {srst, adc_en, cnt_ch, halv, o_sh, c_sh, m_sh};

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    nref <= nref + int'(ref_out === 1'b1);
    nfb <= nfb + int'(fb_out === 1'b1);
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // access tasks and compare
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    port_req = '{1'b1, 1'b0, a, d};
    wait_n(1);
    port_req = '0;
    wait_n(2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    port_req = '{1'b0, 1'b1, a, 8'h00};
    wait_n(1);
    port_req = '0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
    wait_n(1);
  endtask

  task automatic fld(input logic [12:0] v);
    out_div_wr = {1'b1, v[2:0]};
    cal_div_wr = {1'b1, v[3:0]};
    osc_wr = {1'b1, v};
    wait_n(1);
    out_div_wr = '0;
    cal_div_wr = '0;
    osc_wr = '0;
    wait_n(2);
  endtask

  task automatic act(input logic [12:0] v);
    chk("out_div", {13'h0000, v[2:0]}, {13'h0000, odiv});
    chk("cal_div", {12'h000, v[3:0]}, {12'h000, c2, c1});
    chk("osc", {3'h0, v}, {3'h0, core, oband, bias});
  endtask

  task automatic upd();
    update_event = 1'b1;
    wait_n(1);
    update_event = 1'b0;
    wait_n(2);
  endtask

  task automatic ticks(input int n, input logic [15:0] exp);
    nref = 0;
    nfb = 0;
    cal_active = 1'b1;
    tick = 1'b1;
    wait_n(n);
    tick = 1'b0;
    wait_n(3);
    cal_active = 1'b0;
    wait_n(2);
    chk("ticks", exp, {nref[7:0], nfb[7:0]});
  endtask

  task automatic end_of_test();
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    wait_n(4);
    reset = 1'b0;
    for (int i = 0; i < 9; i++) rd(8'h20 + 8'(i), 8'h00);
    chk("ctl", 16'h0000, {9'h000, ctl});
    for (int i = 0; i < 9; i++) wr(8'h20 + 8'(i), pat[i]);
    for (int i = 0; i < 9; i++) rd(8'h20 + 8'(i), pat[i]);
    chk("ctl", 16'h003f, {9'h000, ctl});
    chk("band", 16'h007e, {8'h00, band});
    chk("tmo", 16'h5aa5, {1'b0, tmo});
    fld(13'h1b6d);
    act(13'h0000);
    upd();
    act(13'h1b6d);
    wr(8'h23, 8'h7f);
    wr(8'h24, 8'hfb);
    chk("cnt_halv", 16'h0000, {14'h0000, cnt_ch, halv});
    wr(8'h25, 8'h00);
    wr(8'h28, 8'h5a);
    fld(13'h04b2);
    act(13'h04b2);
    ticks(4, 16'h0404);
    wr(8'h24, 8'h04);
    ticks(1, 16'h0000);
    ticks(4, 16'h0202);
    wr(8'h20, 8'h18);
    act(13'h0000);
    fld(13'h0a5a);
    act(13'h0000);
    ticks(2, 16'h0000);
    rd(8'h26, 8'h7e);
    rd(8'h20, 8'h18);
    wr(8'h20, 8'h08);
    fld(13'h0a5a);
    act(13'h0a5a);
    wr(8'h29, 8'hff);
    rd(8'h29, 8'h00);
    rd(8'h21, 8'ha5);
    end_of_test();
  end
endmodule // tb
